// >>> hdl/otps_burn_verify.sv
// Operation
// - Signature covers bytes 0x02..0x1D ascending
// - MISR: shift, XOR byte, XOR 29 on carry
// - Unlocked part boots into communication mode
// - Core 0x20 write restarts angle measurement
// - Measured angle register shows current angle
// - Signature byte lives at index 0x1E
// - Burn only after 0x70 then 0x51
// - Burn completes in programming time window
// - Core 0x40 guard threshold, 0x00 normal
// - Threshold change reloads shadow after refresh time
// - Locked part boots into functional mode
// - Signature mismatch holds output hi-z until reset
// - Config bit selects lower or upper band
`timescale 1ns/10ps
`default_nettype none
module otps_burn_verify
	import otps_pkg::*;
#(
	parameter int BURN_CYC    = BURN_CYCLES,
	parameter int REFRESH_CYC = REFRESH_CYCLES
)(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        nPor,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] angleIn,
	output logic             dspReset,
	output logic             guardBand,
	output logic             commMode,
	output logic             funcMode,
	output logic             outDriveEn,
	output logic             failBandHigh,
	output logic             irq
);

	localparam logic [CNT_W-1:0] BURN_LAST = CNT_W'(BURN_CYC - 1);
	localparam logic [CNT_W-1:0] REFR_LAST = CNT_W'(REFRESH_CYC - 1);
	localparam logic [CNT_W-1:0] BURN_LEN  = CNT_W'(BURN_CYC);
	localparam int               SIG_SPAN  = SIG_BYTES - 1;

	// One signature step: shift, fold in the byte, fold the carry
	function automatic logic [7:0] misr_step(input logic [7:0] s, input logic [7:0] d);
		misr_step = {s[6:0], 1'b0} ^ d ^ (s[7] ? MISR_POLY : 8'h00);
	endfunction

	// Word index of an aligned address; misaligned maps to an unused index
	function automatic logic [9:0] reg_index(input logic [11:0] a);
		reg_index = (a[1:0] == 2'h0) ? a[11:2] : 10'h3ff;
	endfunction

	otps_state_t             state_reg, state_next;
	logic [CNT_W-1:0]        cnt_reg, cnt_next;
	logic [4:0]              ckIdx_reg, ckIdx_next;
	logic [7:0]              sig_reg, sig_next;
	logic [CFG_BYTES-1:0][7:0] shadow_reg, shadow_next;
	logic [CFG_BYTES-1:0][7:0] fuse_reg, fuse_next;
	logic [7:0]              core_reg, core_next;
	logic                    armed_reg, armed_next;
	logic                    guard_reg, guard_next;
	logic                    dsp_reg, dsp_next;
	logic [13:0]             angle_reg, angle_next;
	otps_evt_t               status_reg, status_next;
	otps_evt_t               mask_reg, mask_next;
	otps_evt_t               evt;
	logic [31:0]             rdata_reg, rdata_next;
	logic                    err_reg, err_next;
	logic [CNT_W-1:0]        burnAge_reg, burnAge_next;
	logic                    porMeta_reg;
	logic                    porSync_reg;

	logic       setup;
	logic       wrAcc;
	logic [9:0] wIdx;
	logic [9:0] sIdx;
	logic       inComm;
	logic       locked;

	// Zero-wait slave: data is prepared in setup, answered in access
	assign setup  = psel & ~penable;
	assign wrAcc  = psel & penable & pwrite;
	assign wIdx   = reg_index(paddr);
	assign sIdx   = reg_index(paddr);
	assign inComm = (state_reg == ST_COMM);
	assign locked = shadow_reg[IDX_LOCK[4:0]][BIT_LOCK];

	// Control sequencer: boot load, signature check, modes, burn, refresh
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		ckIdx_next  = ckIdx_reg;
		sig_next    = sig_reg;
		shadow_next = shadow_reg;
		fuse_next   = fuse_reg;
		core_next   = core_reg;
		armed_next  = armed_reg;
		guard_next  = guard_reg;
		dsp_next    = 1'b0;
		evt         = EVT_RESET;
		case (state_reg)
			ST_LOAD: begin
				shadow_next = fuse_reg;
				ckIdx_next  = IDX_SIG_FIRST[4:0];
				sig_next    = MISR_SEED;
				state_next  = ST_CHECK;
			end
			ST_CHECK: begin
				sig_next   = misr_step(sig_reg, shadow_reg[ckIdx_reg]);
				ckIdx_next = ckIdx_reg + 5'h01;
				if (ckIdx_reg == IDX_SIG_LAST[4:0]) begin
					if (!locked) begin
						state_next = ST_COMM;
					end else if (sig_next == shadow_reg[IDX_SIGNATURE[4:0]]) begin
						state_next = ST_FUNC;
					end else begin
						state_next  = ST_FAIL;
						evt.sigFail = 1'b1;
					end
				end
			end
			ST_COMM: begin
				if (wrAcc) begin
					armed_next = 1'b0;
					if (wIdx <= IDX_SIGNATURE) begin
						shadow_next[wIdx[4:0]] = pwdata[7:0];
					end else if (wIdx == IDX_CORE_CTRL) begin
						core_next = pwdata[7:0];
						if (pwdata[7:0] == CORE_DSP_RST) begin
							dsp_next = 1'b1;
						end
						if (pwdata[7:0] == CORE_GUARD || pwdata[7:0] == CORE_NORMAL) begin
							guard_next = (pwdata[7:0] == CORE_GUARD);
							if ((pwdata[7:0] == CORE_GUARD) != guard_reg) begin
								cnt_next   = '0;
								state_next = ST_REFRESH;
							end
						end
					end else if (wIdx == IDX_KEY_FIRST) begin
						armed_next = (pwdata[7:0] == KEY_FIRST_VAL);
					end else if (wIdx == IDX_KEY_SECOND && armed_reg && pwdata[7:0] == KEY_SECOND_VAL) begin
						cnt_next   = '0;
						state_next = ST_BURN;
					end
				end
			end
			ST_BURN: begin
				// Fuses only ever go from 0 to 1, so the image is OR-ed in
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == BURN_LAST) begin
					fuse_next    = fuse_reg | shadow_reg;
					evt.burnDone = 1'b1;
					state_next   = ST_COMM;
				end
			end
			ST_REFRESH: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == REFR_LAST) begin
					shadow_next     = fuse_reg;
					evt.refreshDone = 1'b1;
					state_next      = ST_COMM;
				end
			end
			ST_FUNC: begin
				state_next = ST_FUNC;
			end
			ST_FAIL: begin
				state_next = ST_FAIL;
			end
			default: begin
				state_next = ST_LOAD;
			end
		endcase
		// The fuse array survives a device reset; only power-on clears it
		if (!porSync_reg) begin
			fuse_next = '0;
		end
	end

	always_ff @(posedge mclk) begin
		fuse_reg <= fuse_next;
		if (!nrst) begin
			state_reg  <= ST_LOAD;
			cnt_reg    <= '0;
			ckIdx_reg  <= 5'h00;
			sig_reg    <= MISR_SEED;
			shadow_reg <= '0;
			core_reg   <= CFG_RESET;
			armed_reg  <= 1'b0;
			guard_reg  <= 1'b0;
			dsp_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			ckIdx_reg  <= ckIdx_next;
			sig_reg    <= sig_next;
			shadow_reg <= shadow_next;
			core_reg   <= core_next;
			armed_reg  <= armed_next;
			guard_reg  <= guard_next;
			dsp_reg    <= dsp_next;
		end
	end

	// Power-on clear comes from a pin; retimed, and not reset so nrst spares the fuses
	always_ff @(posedge mclk) begin
		porMeta_reg <= nPor;
		porSync_reg <= porMeta_reg;
	end

	// Burn length gauge kept apart from the sequencer's own counter
	always_comb begin
		burnAge_next = (state_reg == ST_BURN) ? burnAge_reg + 1'b1 : '0;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			burnAge_reg <= '0;
		end else begin
			burnAge_reg <= burnAge_next;
		end
	end

	// Angle tracking; a core restart drops the old value so a fresh one is seen
	always_comb begin
		angle_next = dsp_reg ? 14'h0000 : angleIn;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			angle_reg <= 14'h0000;
		end else begin
			angle_reg <= angle_next;
		end
	end

	// Interrupt status and mask; a new event wins over a same-cycle clear
	always_comb begin
		status_next = status_reg;
		mask_next   = mask_reg;
		if (wrAcc && wIdx == IDX_IRQ_STATUS) begin
			status_next = status_reg & ~otps_evt_t'(pwdata[2:0]);
		end
		if (wrAcc && wIdx == IDX_IRQ_MASK) begin
			mask_next = otps_evt_t'(pwdata[2:0]);
		end
		status_next = status_next | evt;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			status_reg <= EVT_RESET;
			mask_reg   <= EVT_RESET;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
		end
	end

	// Read data and error are latched in setup so they come from flops
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup) begin
			rdata_next = 32'h00000000;
			err_next   = 1'b0;
			if (sIdx <= IDX_SIGNATURE) begin
				rdata_next = {24'h000000, shadow_reg[sIdx[4:0]]};
				err_next   = pwrite & ~inComm;
			end else if (sIdx == IDX_ANGLE) begin
				rdata_next = {18'h00000, angle_reg};
				err_next   = pwrite;
			end else if (sIdx == IDX_CORE_CTRL) begin
				rdata_next = {24'h000000, core_reg};
				err_next   = pwrite & ~inComm;
			end else if (sIdx == IDX_KEY_FIRST || sIdx == IDX_KEY_SECOND) begin
				err_next   = ~pwrite | ~inComm;
			end else if (sIdx == IDX_IRQ_STATUS) begin
				rdata_next = {29'h00000000, status_reg};
			end else if (sIdx == IDX_IRQ_MASK) begin
				rdata_next = {29'h00000000, mask_reg};
			end else if (sIdx == IDX_MODE) begin
				rdata_next = {29'h00000000, state_reg};
			end else begin
				err_next = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_reg <= 32'h00000000;
			err_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	// Output stage; failure parks the driver in hi-z
	assign prdata       = rdata_reg;
	assign pready       = psel & penable;
	assign pslverr      = psel & penable & err_reg;
	assign dspReset     = dsp_reg;
	assign guardBand    = guard_reg;
	assign commMode     = inComm;
	assign funcMode     = (state_reg == ST_FUNC);
	assign outDriveEn   = (state_reg == ST_FUNC);
	assign failBandHigh = shadow_reg[IDX_FBAND[4:0]][BIT_FBAND];
	assign irq          = |(status_reg & mask_reg);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_key_first;
		wrAcc && inComm && wIdx == IDX_KEY_FIRST && pwdata[7:0] == KEY_FIRST_VAL;
	endsequence
	sequence s_key_second;
		wrAcc && inComm && wIdx == IDX_KEY_SECOND && pwdata[7:0] == KEY_SECOND_VAL;
	endsequence
	sequence s_sig_bad;
		state_reg == ST_CHECK && ckIdx_reg == IDX_SIG_LAST[4:0] && locked && sig_next != shadow_reg[IDX_SIGNATURE[4:0]];
	endsequence

	a_burn_key_seq: assert property ($rose(state_reg == ST_BURN) |-> $past(armed_reg) && $past(wIdx) == IDX_KEY_SECOND)
		else $error("burn began without the key sequence");
	a_key_pair_go: assert property (s_key_first ##1 (!wrAcc)[*2] ##1 s_key_second |=> state_reg == ST_BURN)
		else $error("key sequence did not start the burn");
	a_burn_ends: assert property (state_reg == ST_BURN && cnt_reg == BURN_LAST |=> state_reg == ST_COMM && status_reg.burnDone)
		else $error("burn did not finish at the programming time");
	a_burn_bound: assert property (state_reg == ST_BURN |-> cnt_reg <= BURN_LAST)
		else $error("burn counter ran past the programming time");
	a_fuse_guard: assert property (porSync_reg && state_reg != ST_BURN |=> $stable(fuse_reg))
		else $error("fuses changed outside a burn");
	a_fail_hold: assert property (state_reg == ST_FAIL |=> state_reg == ST_FAIL && !outDriveEn)
		else $error("failure state left before reset");
	a_boot_mode: assert property (state_reg == ST_CHECK && ckIdx_reg == IDX_SIG_LAST[4:0] && !locked |=> state_reg == ST_COMM)
		else $error("unlocked part did not enter communication mode");
	a_boot_func: assert property (state_reg == ST_CHECK && ckIdx_reg == IDX_SIG_LAST[4:0] && locked && sig_next == shadow_reg[IDX_SIGNATURE[4:0]] |=> funcMode && outDriveEn)
		else $error("locked part with good signature not functional");
	a_sig_span: assert property ($rose(state_reg == ST_CHECK) |-> ckIdx_reg == IDX_SIG_FIRST[4:0] ##[SIG_SPAN:SIG_SPAN] ckIdx_reg == IDX_SIG_LAST[4:0])
		else $error("signature did not walk the documented byte span");
	a_dsp_pulse: assert property (wrAcc && inComm && wIdx == IDX_CORE_CTRL && pwdata[7:0] == CORE_DSP_RST |=> dspReset ##1 !dspReset)
		else $error("core restart pulse missing or stretched");
	a_angle_track: assert property (!dspReset |=> angle_reg == $past(angleIn))
		else $error("angle register does not follow the measurement");
	a_guard_sel: assert property (wrAcc && inComm && wIdx == IDX_CORE_CTRL && pwdata[7:0] == CORE_GUARD |=> guardBand)
		else $error("guard threshold not selected");
	a_refresh_go: assert property ($changed(guardBand) |-> state_reg == ST_REFRESH && cnt_reg == '0)
		else $error("threshold change did not start a refresh");
	a_refresh_end: assert property (state_reg == ST_REFRESH && cnt_reg == REFR_LAST |=> shadow_reg == $past(fuse_reg))
		else $error("refresh did not reload shadow from fuses");
	a_fail_flag: assert property (s_sig_bad |=> state_reg == ST_FAIL && status_reg.sigFail)
		else $error("signature mismatch did not raise the failure");
	a_burn_span: assert property ($fell(state_reg == ST_BURN) |-> burnAge_reg == BURN_LEN)
		else $error("burn did not last the programming time");
	a_burn_shadow: assert property (wrAcc && state_reg == ST_BURN |=> $stable(shadow_reg))
		else $error("shadow changed by a write during the burn");
	a_dsp_angle: assert property (dspReset |=> angle_reg == 14'h0000)
		else $error("core restart did not drop the old angle");
	a_guard_normal: assert property (wrAcc && inComm && wIdx == IDX_CORE_CTRL && pwdata[7:0] == CORE_NORMAL |=> !guardBand)
		else $error("normal threshold not restored");
	a_key_disarm: assert property (wrAcc && inComm && wIdx != IDX_KEY_FIRST |=> !armed_reg)
		else $error("burn key stayed armed after another write");
	a_refuse_flag: assert property (psel && penable && pwrite && wIdx <= IDX_SIGNATURE &&
		(funcMode || state_reg == ST_FAIL || state_reg == ST_BURN) |-> pslverr)
		else $error("settings write outside communication mode not refused");

endmodule
`default_nettype wire

// >>> hdl/otps_pkg.sv
package otps_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CFG_FIRST  = 10'h000;
	localparam logic [9:0] IDX_SIG_FIRST  = 10'h002;
	localparam logic [9:0] IDX_SIG_LAST   = 10'h01d;
	localparam logic [9:0] IDX_SIGNATURE  = 10'h01e;
	localparam logic [9:0] IDX_ANGLE      = 10'h020;
	localparam logic [9:0] IDX_CORE_CTRL  = 10'h023;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h040;
	localparam logic [9:0] IDX_IRQ_MASK   = 10'h041;
	localparam logic [9:0] IDX_MODE       = 10'h042;
	localparam logic [9:0] IDX_KEY_FIRST  = 10'h062;
	localparam logic [9:0] IDX_KEY_SECOND = 10'h063;
	localparam int         CFG_BYTES      = 31;
	localparam int         SIG_BYTES      = 28;

	// Field positions inside the configuration bytes
	localparam logic [9:0] IDX_LOCK       = 10'h01d;
	localparam int         BIT_LOCK       = 7;
	localparam logic [9:0] IDX_FBAND      = 10'h01c;
	localparam int         BIT_FBAND      = 0;

	// Command values
	localparam logic [7:0] CORE_DSP_RST   = 8'h20;
	localparam logic [7:0] CORE_GUARD     = 8'h40;
	localparam logic [7:0] CORE_NORMAL    = 8'h00;
	localparam logic [7:0] KEY_FIRST_VAL  = 8'h70;
	localparam logic [7:0] KEY_SECOND_VAL = 8'h51;
	localparam logic [7:0] MISR_POLY      = 8'h1d;
	localparam logic [7:0] MISR_SEED      = 8'h00;

	// Reset values
	localparam logic [7:0] CFG_RESET      = 8'h00;
	localparam logic [2:0] EVT_RESET      = 3'h0;

	// Timing
	localparam int         CLK_MHZ        = 50;
	localparam int         BURN_TIME_US   = 10000;
	localparam int         REFRESH_TIME_US = 5000;
	localparam int         BURN_CYCLES    = BURN_TIME_US * CLK_MHZ;
	localparam int         REFRESH_CYCLES = REFRESH_TIME_US * CLK_MHZ;
	localparam int         CNT_W          = 20;

	typedef enum logic [2:0] {ST_LOAD, ST_CHECK, ST_COMM, ST_FUNC, ST_FAIL, ST_BURN, ST_REFRESH} otps_state_t;

	// Interrupt events, one bit each, same layout in status and mask
	typedef struct packed {
		logic sigFail;
		logic refreshDone;
		logic burnDone;
	} otps_evt_t;
endpackage

// >>> test/otps_station.sv
`timescale 1ns/10ps
`default_nettype none
module otps_station (
	input  wire logic        mclk,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata
);
	// Idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
	end

	// One APB transfer; a spare edge first so a strobe is never set twice in one step
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released lines carry garbage so a stale value is never mistaken for a live one
		paddr   <= ~paddr;
		pwdata  <= ~pwdata;
	endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import otps_pkg::*;
	logic        mclk, nrst, nPor, psel, penable, pwrite, pready, pslverr;
	logic        dspReset, guardBand, commMode, funcMode, outDriveEn, failBandHigh, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [13:0] angleIn;
	logic [33:0] expQ[$];
	logic [7:0]  cfg[0:31];
	logic [7:0]  sig;
	integer      seed, failures, total_checks, cyc, dspCnt;

	// Short burn and refresh times keep the run brief
	otps_burn_verify #(.BURN_CYC(20), .REFRESH_CYC(10)) otps_burn_verify_inst (
		.mclk(mclk), .nrst(nrst), .nPor(nPor), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.angleIn(angleIn), .dspReset(dspReset), .guardBand(guardBand), .commMode(commMode),
		.funcMode(funcMode), .outDriveEn(outDriveEn), .failBandHigh(failBandHigh), .irq(irq));
	otps_station otps_station_inst (
		.mclk(mclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watcher: each completed transfer is matched with the oldest note
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (dspReset === 1'b1)
			dspCnt <= dspCnt + 1;
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (expQ.size() == 0)
				chk("queue", 32'h1, 32'h0);
			else begin
				chk("pslverr", 32'(expQ[0][32]), 32'(pslverr));
				if (!expQ[0][33])
					chk("prdata", expQ[0][31:0], prdata);
				void'(expQ.pop_front());
			end
		end
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic acc(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic e,
			input logic [31:0] x);
		expQ.push_back({w, e, x});
		otps_station_inst.xfer(w, idx, d);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		acc(1'b1, idx, d, 1'b0, 32'h0);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [31:0] x);
		acc(1'b0, idx, 8'h00, 1'b0, x);
	endtask

	// Reset for 20 cycles; por also clears the fuses, then wait for boot to settle
	task automatic rst(input logic por);
		nrst <= 1'b0;
		nPor <= ~por;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		nPor <= 1'b1;
		for (int k = 0; k < 40 && (commMode | funcMode) !== 1'b1; k++)
			@(posedge mclk);
		wr(IDX_IRQ_MASK, 8'h07);
	endtask

	task automatic wait_irq(input logic [7:0] st);
		for (int k = 0; k < 100 && irq !== 1'b1; k++)
			@(posedge mclk);
		rd(IDX_IRQ_STATUS, 32'(st));
		wr(IDX_IRQ_STATUS, st);
		#1 chk("irq", 32'h0, 32'(irq));
	endtask

	function automatic logic [7:0] misr();
		logic [7:0] m;
		m = 8'h00;
		for (int j = 2; j <= 29; j++)
			m = ({m[6:0], 1'b0} ^ cfg[j]) ^ (m[7] ? 8'h1d : 8'h00);
		return m;
	endfunction

	// Load settings, read them back, then burn; good=0 plants a wrong signature
	task automatic prog(input logic fb, input logic good);
		for (int j = 0; j < 32; j++)
			cfg[j] = (j >= 10) ? 8'($random(seed)) : 8'h00;
		cfg[29][7] = 1'b1;
		cfg[28][0] = fb;
		sig = misr() ^ {7'h0, ~good};
		cfg[30] = sig;
		for (int j = 10; j <= 30; j++)
			wr(10'(j), cfg[j]);
		for (int j = 10; j <= 30; j++)
			rd(10'(j), 32'(cfg[j]));
		wr(IDX_KEY_SECOND, KEY_SECOND_VAL);
		rd(IDX_MODE, 32'h2);
		wr(IDX_KEY_FIRST, KEY_FIRST_VAL);
		wr(IDX_KEY_SECOND, KEY_SECOND_VAL);
		rd(IDX_MODE, 32'h5);
		acc(1'b1, 10'h00a, 8'h55, 1'b1, 32'h0);
		wait_irq(8'h01);
	endtask

	initial begin
		seed = 51;
		failures = 0;
		total_checks = 0;
		cyc = 0;
		dspCnt = 0;
		nrst = 1'b0;
		nPor = 1'b0;
		angleIn = 14'($random(seed));
		rst(1'b1);
		chk("commMode", 32'h1, 32'(commMode));
		chk("outDriveEn", 32'h0, 32'(outDriveEn));
		rd(IDX_MODE, 32'h2);
		acc(1'b0, 10'h030, 8'h00, 1'b1, 32'h0);
		rd(IDX_ANGLE, 32'(angleIn));
		wr(IDX_CORE_CTRL, CORE_DSP_RST);
		repeat (3) @(posedge mclk);
		chk("dspCnt", 32'h1, 32'(dspCnt));
		wr(IDX_LOCK, 8'h80);
		rst(1'b0);
		rd(IDX_LOCK, 32'h0);
		$display("test boot done");
		prog(1'b1, 1'b1);
		// Guard band is used only here, straight after the burn
		for (int g = 0; g < 2; g++) begin
			wr(IDX_SIGNATURE, 8'h00);
			wr(IDX_CORE_CTRL, g ? CORE_NORMAL : CORE_GUARD);
			#1 chk("guardBand", 32'(g == 0), 32'(guardBand));
			wait_irq(8'h02);
			rd(IDX_SIGNATURE, 32'(sig));
			rd(IDX_FBAND, 32'(cfg[28]));
		end
		rst(1'b0);
		chk("funcMode", 32'h1, 32'(funcMode));
		chk("outDriveEn", 32'h1, 32'(outDriveEn));
		chk("failBandHigh", 32'h1, 32'(failBandHigh));
		acc(1'b1, 10'h00a, 8'h00, 1'b1, 32'h0);
		$display("test burn done");
		rst(1'b1);
		prog(1'b0, 1'b0);
		rst(1'b0);
		rd(IDX_IRQ_STATUS, 32'h4);
		rd(IDX_MODE, 32'h4);
		repeat (50) @(posedge mclk);
		chk("outDriveEn", 32'h0, 32'(outDriveEn));
		chk("funcMode", 32'h0, 32'(funcMode));
		chk("failBandHigh", 32'h0, 32'(failBandHigh));
		$display("test signature fail done");
		end_of_test();
	end
endmodule
`default_nettype wire
